// ==== rmc_regs.vh ====
// Register offsets, field positions and reset values of the radio modem configuration bank.
// Assumes an 8-bit register port addressed by a 7-bit register index.
`ifndef RMC_REGS_VH
`define RMC_REGS_VH

// ****************************************
// Offsets
// ****************************************
`define RMC_OFS_SLOT3 7'h15
`define RMC_OFS_SLOT2 7'h16
`define RMC_OFS_SLOT1 7'h17
`define RMC_OFS_RAMP 7'h18
`define RMC_OFS_RATE_M 7'h1A
`define RMC_OFS_MOD 7'h1B
`define RMC_OFS_DEV 7'h1C
`define RMC_OFS_FILT 7'h1D
`define RMC_OFS_FC_CTL 7'h1E
`define RMC_OFS_FC_LEN 7'h1F
`define RMC_OFS_FC_GAIN 7'h20
`define RMC_OFS_STR_FLT 7'h21
`define RMC_OFS_STR_TH 7'h22
`define RMC_OFS_TIMING 7'h23
`define RMC_OFS_GAIN_MEAS 7'h24
`define RMC_OFS_GAIN_TH 7'h25
`define RMC_OFS_GAIN_EN 7'h26
`define RMC_OFS_ANT 7'h27

// ****************************************
// Reset values
// ****************************************
`define RMC_RST_SLOT3 8'h40
`define RMC_RST_SLOT2 8'h4E
`define RMC_RST_SLOT1 8'h00
`define RMC_RST_RAMP 8'h07
`define RMC_RST_RATE_M 8'h83
`define RMC_RST_MOD 8'h1A
`define RMC_RST_DEV 8'h45
`define RMC_RST_FILT 8'h23
`define RMC_RST_FC_CTL 8'h48
`define RMC_RST_FC_LEN 8'h18
`define RMC_RST_FC_GAIN 8'h25
`define RMC_RST_STR_FLT 8'hE3
`define RMC_RST_STR_TH 8'h24
`define RMC_RST_TIMING 8'h58
`define RMC_RST_GAIN_MEAS 8'h22
`define RMC_RST_GAIN_TH 8'h65
`define RMC_RST_GAIN_EN 8'h8A
`define RMC_RST_ANT 8'h05

// ****************************************
// Writable-bit masks (reserved bits read zero)
// ****************************************
`define RMC_MASK_SLOT 8'h7F
`define RMC_MASK_ANT 8'h1F
`define RMC_MASK_ALL 8'hFF

// ****************************************
// Field positions
// ****************************************
`define RMC_TOP_IDX 2:0
`define RMC_STEP_LEN 4:3
`define RMC_RAMP_ON 5
`define RMC_CAP 7:6
`define RMC_RATE_EXP 3:0
`define RMC_KIND 5:4
`define RMC_SHAPE 6
`define RMC_CW 7
`define RMC_DEV_MANT 2:0
`define RMC_TLOOP 3
`define RMC_HI_NIB 7:4
`define RMC_LO_NIB 3:0
`define RMC_FC_LEAK 4:0
`define RMC_FC_POINT 5
`define RMC_FC_ON 6
`define RMC_FC_HOLD 7
`define RMC_DECAY 1:0
`define RMC_CS_MODE 3:2
`define RMC_PF_SIZE 4
`define RMC_PROP 7:5
`define RMC_GAIN_ON 7
`define RMC_ANT_MEAS 2:0
`define RMC_ANT_ON 3
`define RMC_DROP 4

// ****************************************
// Ramp timing
// ****************************************
`define RMC_EIGHTH_SHIFT 3
`define RMC_RST_TOP_IDX 3'h7
`define RMC_PCNT_W 16

`endif

// ==== rmc_reg8.v ====
// One 8-bit configuration register with reset value and writable mask.
// Assumes a write strobe synchronous to core_clk.
`timescale 1ns/1ns
module rmc_reg8 #(
  parameter [7:0] RST_VAL = 8'h00,
  parameter [7:0] WR_MASK = 8'hFF
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // Write
  input wire wr_en,
  input wire [7:0] wr_data,
  // Value
  output reg [7:0] value
);
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      value <= RST_VAL & WR_MASK;
    end else if (wr_en) begin
      value <= wr_data & WR_MASK;
    end
  end
endmodule // rmc_reg8

// ==== rmc_config_bank.v ====
// Radio modem configuration register bank with power ramp sequencer.
// Assumes a synchronous byte register port from the serial interface, and
// a bit-period length in core_clk cycles supplied by the modem.
`timescale 1ns/1ns
`include "rmc_regs.vh"

// Function
// - Eight 7-bit power slots, top bit reserved; 3-bit index picks level or ramp end.
// - Power steps through slots up to top index only when ramp enable set.
// - Each ramp step lasts the 2-bit field times one eighth bit period.
// - Load capacitor field decodes to 0, 1.2, 2.4 or 3.6 pF.
// - Data rate comes from 8-bit mantissa register and 4-bit exponent field.
// - Continuous-wave bit high sends an unmodulated carrier.
// - Shaping bit zero gives BT of 1, one gives BT of 0.5.
// - Modulation kind: 0 2-FSK, 1 GFSK, 2 ASK/OOK, 3 MSK.
// - Deviation uses 4-bit exponent upper nibble and 3-bit mantissa low bits.
// - Deviation bit 3 selects phase-locked or delay-locked symbol timing.
// - Channel filter uses mantissa upper nibble and exponent lower nibble.
// - With hold-on-sync set, correction freezes after sync word detection.
// - Correction runs while enabled; mode picks slicer or second conversion loop.
// - Fast and slow correction gains are 4-bit log2; fast length separate.
// - Strength threshold in half-dB steps, 0x14 meaning -120 dBm.
// - On-off peak decay: 3 slowest, 0 fastest.
// - Post-filter holds 8 symbols when bit zero, 16 when one.
// - Proportional gain 3-bit log2; integral gain used only in phase-locked mode.
// - Gain control runs when enable bit 7 set, with thresholds and measure time.
// - Blanking bit drops received data while signal under carrier sense threshold.
// - Antenna switching only when enabled, measure field sets evaluation period.
module rmc_config_bank #(
  parameter NREG = 18
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // Register port
  input wire [6:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg reg_hit,
  // Bank slots 4..8 value supply (from neighbouring bank)
  input wire [34:0] upper_slots,
  // Transmit power path
  input wire tx_active,
  input wire [`RMC_PCNT_W-1:0] bit_period_cycles,
  output reg [6:0] power_level,
  output reg [2:0] power_index,
  output reg ramp_busy,
  output reg [5:0] load_cap_tenths_pf,
  // Modulator
  output reg [7:0] rate_mant,
  output reg [3:0] rate_exp,
  output reg carrier_only_tx,
  output reg gauss_bt_half,
  output reg [1:0] mod_kind,
  output reg [3:0] dev_exp,
  output reg [2:0] dev_mant,
  output reg timing_loop_kind,
  output reg [3:0] filt_mant,
  output reg [3:0] filt_exp,
  // Frequency correction
  input wire sync_seen,
  input wire rx_frame_start,
  output reg fc_run,
  output reg fc_loop_point,
  output reg [4:0] fc_leak,
  output reg [7:0] fc_fast_len,
  output reg [3:0] fc_fast_gain,
  output reg [3:0] fc_slow_gain,
  // Signal strength and timing recovery
  input wire [7:0] strength_now,
  output reg strength_above,
  output reg [3:0] strength_filt_gain,
  output reg [1:0] cs_mode,
  output reg [1:0] onoff_peak_decay,
  output reg [4:0] postfilter_size,
  output reg [2:0] timing_prop_gain,
  output reg [3:0] timing_int_gain,
  // Gain control and antenna
  output reg gain_loop_on,
  output reg [3:0] gain_high_th,
  output reg [3:0] gain_low_th,
  output reg [3:0] gain_measure_len,
  input wire rx_data_valid,
  output reg rx_store_en,
  output reg antenna_swap_on,
  output reg [2:0] antenna_measure_len
);

  // ****************************************
  // Register storage
  // ****************************************
  wire [8*NREG-1:0] regs_flat;
  wire [7:0] r_slot3 = regs_flat[7:0];
  wire [7:0] r_slot2 = regs_flat[15:8];
  wire [7:0] r_slot1 = regs_flat[23:16];
  wire [7:0] r_ramp = regs_flat[31:24];
  wire [7:0] r_rate = regs_flat[39:32];
  wire [7:0] r_mod = regs_flat[47:40];
  wire [7:0] r_dev = regs_flat[55:48];
  wire [7:0] r_filt = regs_flat[63:56];
  wire [7:0] r_fcc = regs_flat[71:64];
  wire [7:0] r_fcl = regs_flat[79:72];
  wire [7:0] r_fcg = regs_flat[87:80];
  wire [7:0] r_sflt = regs_flat[95:88];
  wire [7:0] r_sth = regs_flat[103:96];
  wire [7:0] r_tim = regs_flat[111:104];
  wire [7:0] r_gms = regs_flat[119:112];
  wire [7:0] r_gth = regs_flat[127:120];
  wire [7:0] r_gen = regs_flat[135:128];
  wire [7:0] r_ant = regs_flat[143:136];

  wire [6:0] ofs_tab [0:NREG-1];
  assign ofs_tab[0] = `RMC_OFS_SLOT3;
  assign ofs_tab[1] = `RMC_OFS_SLOT2;
  assign ofs_tab[2] = `RMC_OFS_SLOT1;
  assign ofs_tab[3] = `RMC_OFS_RAMP;
  assign ofs_tab[4] = `RMC_OFS_RATE_M;
  assign ofs_tab[5] = `RMC_OFS_MOD;
  assign ofs_tab[6] = `RMC_OFS_DEV;
  assign ofs_tab[7] = `RMC_OFS_FILT;
  assign ofs_tab[8] = `RMC_OFS_FC_CTL;
  assign ofs_tab[9] = `RMC_OFS_FC_LEN;
  assign ofs_tab[10] = `RMC_OFS_FC_GAIN;
  assign ofs_tab[11] = `RMC_OFS_STR_FLT;
  assign ofs_tab[12] = `RMC_OFS_STR_TH;
  assign ofs_tab[13] = `RMC_OFS_TIMING;
  assign ofs_tab[14] = `RMC_OFS_GAIN_MEAS;
  assign ofs_tab[15] = `RMC_OFS_GAIN_TH;
  assign ofs_tab[16] = `RMC_OFS_GAIN_EN;
  assign ofs_tab[17] = `RMC_OFS_ANT;

  rmc_reg8 #(.RST_VAL(`RMC_RST_SLOT3), .WR_MASK(`RMC_MASK_SLOT)) u_slot3 (
    .core_clk(core_clk), .rst_b(rst_b), .wr_en(reg_wr && reg_addr == `RMC_OFS_SLOT3),
    .wr_data(reg_wdata), .value(regs_flat[7:0]));
  rmc_reg8 #(.RST_VAL(`RMC_RST_SLOT2), .WR_MASK(`RMC_MASK_SLOT)) u_slot2 (
    .core_clk(core_clk), .rst_b(rst_b), .wr_en(reg_wr && reg_addr == `RMC_OFS_SLOT2),
    .wr_data(reg_wdata), .value(regs_flat[15:8]));
  rmc_reg8 #(.RST_VAL(`RMC_RST_SLOT1), .WR_MASK(`RMC_MASK_SLOT)) u_slot1 (
    .core_clk(core_clk), .rst_b(rst_b), .wr_en(reg_wr && reg_addr == `RMC_OFS_SLOT1),
    .wr_data(reg_wdata), .value(regs_flat[23:16]));
  rmc_reg8 #(.RST_VAL(`RMC_RST_RAMP), .WR_MASK(`RMC_MASK_ALL)) u_ramp (
    .core_clk(core_clk), .rst_b(rst_b), .wr_en(reg_wr && reg_addr == `RMC_OFS_RAMP),
    .wr_data(reg_wdata), .value(regs_flat[31:24]));

  // Remaining registers share one pattern; all full width except the antenna register
  genvar gi;
  generate
    for (gi = 4; gi < NREG; gi = gi + 1) begin : g_reg
      localparam [7:0] RV = (gi == 4) ? `RMC_RST_RATE_M : (gi == 5) ? `RMC_RST_MOD :
        (gi == 6) ? `RMC_RST_DEV : (gi == 7) ? `RMC_RST_FILT :
        (gi == 8) ? `RMC_RST_FC_CTL : (gi == 9) ? `RMC_RST_FC_LEN :
        (gi == 10) ? `RMC_RST_FC_GAIN : (gi == 11) ? `RMC_RST_STR_FLT :
        (gi == 12) ? `RMC_RST_STR_TH : (gi == 13) ? `RMC_RST_TIMING :
        (gi == 14) ? `RMC_RST_GAIN_MEAS : (gi == 15) ? `RMC_RST_GAIN_TH :
        (gi == 16) ? `RMC_RST_GAIN_EN : `RMC_RST_ANT;
      localparam [7:0] WM = (gi == 17) ? `RMC_MASK_ANT : `RMC_MASK_ALL;
      rmc_reg8 #(.RST_VAL(RV), .WR_MASK(WM)) u_r (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .wr_en(reg_wr && (reg_addr == ofs_tab[gi])),
        .wr_data(reg_wdata),
        .value(regs_flat[8*gi+7:8*gi]));
    end
  endgenerate

  // ****************************************
  // Read path
  // ****************************************
  integer ri;
  reg [7:0] next_rdata;
  reg next_hit;
  always @* begin
    next_rdata = 8'h00;
    next_hit = 1'b0;
    for (ri = 0; ri < NREG; ri = ri + 1) begin
      if (reg_addr == ofs_tab[ri]) begin
        next_rdata = regs_flat[8*ri +: 8];
        next_hit = 1'b1;
      end
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
      reg_hit <= 1'b0;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
      reg_hit <= next_hit;
    end
  end

  // ****************************************
  // Power slot table
  // ****************************************
  wire [6:0] slot_tab [0:7];
  assign slot_tab[0] = r_slot1[6:0];
  assign slot_tab[1] = r_slot2[6:0];
  assign slot_tab[2] = r_slot3[6:0];
  assign slot_tab[3] = upper_slots[6:0];
  assign slot_tab[4] = upper_slots[13:7];
  assign slot_tab[5] = upper_slots[20:14];
  assign slot_tab[6] = upper_slots[27:21];
  assign slot_tab[7] = upper_slots[34:28];

  // ****************************************
  // Ramp sequencer
  // ****************************************
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_STEP = 3'h2;
  localparam [2:0] ST_HOLD = 3'h4;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [2:0] next_index;
  reg [`RMC_PCNT_W+1:0] step_cnt;
  reg [`RMC_PCNT_W+1:0] next_step_cnt;
  wire [2:0] top_idx = r_ramp[`RMC_TOP_IDX];
  wire [1:0] step_len = r_ramp[`RMC_STEP_LEN];
  wire [`RMC_PCNT_W+1:0] step_cycles;
  wire [`RMC_PCNT_W+1:0] eighth_cycles;

  // One step = step_len eighths of a bit period, never below one cycle
  assign eighth_cycles = {2'b00, bit_period_cycles >> `RMC_EIGHTH_SHIFT};
  assign step_cycles = (step_len == 2'b00 || eighth_cycles == {(`RMC_PCNT_W+2){1'b0}}) ?
    {{(`RMC_PCNT_W+1){1'b0}}, 1'b1} : eighth_cycles * step_len;

  always @* begin
    next_state = state;
    next_index = power_index;
    next_step_cnt = step_cnt;
    case (state)
      ST_IDLE: begin
        if (tx_active && r_ramp[`RMC_RAMP_ON] && top_idx != 3'h0) begin
          next_state = ST_STEP;
          next_index = 3'h0;
          next_step_cnt = step_cycles;
        end else begin
          next_index = top_idx;
        end
      end
      ST_STEP: begin
        if (!tx_active) begin
          next_state = ST_IDLE;
        end else if (step_cnt <= {{(`RMC_PCNT_W+1){1'b0}}, 1'b1}) begin
          next_index = power_index + 3'h1;
          next_step_cnt = step_cycles;
          if (power_index + 3'h1 >= top_idx) begin
            next_state = ST_HOLD;
          end
        end else begin
          next_step_cnt = step_cnt - {{(`RMC_PCNT_W+1){1'b0}}, 1'b1};
        end
      end
      ST_HOLD: begin
        next_index = top_idx;
        if (!tx_active) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_index = top_idx;
      end
    endcase
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      power_index <= `RMC_RST_TOP_IDX;
      step_cnt <= {(`RMC_PCNT_W+2){1'b0}};
      power_level <= 7'h00;
      ramp_busy <= 1'b0;
    end else begin
      state <= next_state;
      power_index <= next_index;
      step_cnt <= next_step_cnt;
      power_level <= slot_tab[next_index];
      ramp_busy <= (next_state == ST_STEP);
    end
  end

  // ****************************************
  // Frequency correction hold
  // ****************************************
  reg fc_frozen;
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fc_frozen <= 1'b0;
    end else if (sync_seen && r_fcc[`RMC_FC_HOLD]) begin
      fc_frozen <= 1'b1;
    end else if (rx_frame_start || !r_fcc[`RMC_FC_HOLD]) begin
      fc_frozen <= 1'b0;
    end
  end

  // ****************************************
  // Decoded outputs
  // ****************************************
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      load_cap_tenths_pf <= 6'h00;
      rate_mant <= 8'h00;
      rate_exp <= 4'h0;
      carrier_only_tx <= 1'b0;
      gauss_bt_half <= 1'b0;
      mod_kind <= 2'h0;
      dev_exp <= 4'h0;
      dev_mant <= 3'h0;
      timing_loop_kind <= 1'b0;
      filt_mant <= 4'h0;
      filt_exp <= 4'h0;
      fc_run <= 1'b0;
      fc_loop_point <= 1'b0;
      fc_leak <= 5'h00;
      fc_fast_len <= 8'h00;
      fc_fast_gain <= 4'h0;
      fc_slow_gain <= 4'h0;
      strength_above <= 1'b0;
      strength_filt_gain <= 4'h0;
      cs_mode <= 2'h0;
      onoff_peak_decay <= 2'h0;
      postfilter_size <= 5'h00;
      timing_prop_gain <= 3'h0;
      timing_int_gain <= 4'h0;
      gain_loop_on <= 1'b0;
      gain_high_th <= 4'h0;
      gain_low_th <= 4'h0;
      gain_measure_len <= 4'h0;
      rx_store_en <= 1'b0;
      antenna_swap_on <= 1'b0;
      antenna_measure_len <= 3'h0;
    end else begin
      load_cap_tenths_pf <= {4'h0, r_ramp[`RMC_CAP]} * 6'h0C;
      rate_mant <= r_rate;
      rate_exp <= r_mod[`RMC_RATE_EXP];
      carrier_only_tx <= r_mod[`RMC_CW];
      gauss_bt_half <= r_mod[`RMC_SHAPE];
      mod_kind <= r_mod[`RMC_KIND];
      dev_exp <= r_dev[`RMC_HI_NIB];
      dev_mant <= r_dev[`RMC_DEV_MANT];
      timing_loop_kind <= r_dev[`RMC_TLOOP];
      filt_mant <= r_filt[`RMC_HI_NIB];
      filt_exp <= r_filt[`RMC_LO_NIB];
      fc_run <= r_fcc[`RMC_FC_ON] && !fc_frozen;
      fc_loop_point <= r_fcc[`RMC_FC_POINT];
      fc_leak <= r_fcc[`RMC_FC_LEAK];
      fc_fast_len <= r_fcl;
      fc_fast_gain <= r_fcg[`RMC_HI_NIB];
      fc_slow_gain <= r_fcg[`RMC_LO_NIB];
      strength_above <= strength_now >= r_sth;
      strength_filt_gain <= r_sflt[`RMC_HI_NIB];
      cs_mode <= r_sflt[`RMC_CS_MODE];
      onoff_peak_decay <= r_sflt[`RMC_DECAY];
      postfilter_size <= r_tim[`RMC_PF_SIZE] ? 5'h10 : 5'h08;
      timing_prop_gain <= r_tim[`RMC_PROP];
      timing_int_gain <= r_dev[`RMC_TLOOP] ? 4'h0 : r_tim[`RMC_LO_NIB];
      gain_loop_on <= r_gen[`RMC_GAIN_ON];
      gain_high_th <= r_gth[`RMC_HI_NIB];
      gain_low_th <= r_gth[`RMC_LO_NIB];
      gain_measure_len <= r_gms[`RMC_LO_NIB];
      rx_store_en <= rx_data_valid && !(r_ant[`RMC_DROP] && strength_now < r_sth);
      antenna_swap_on <= r_ant[`RMC_ANT_ON];
      antenna_measure_len <= r_ant[`RMC_ANT_MEAS];
    end
  end

endmodule // rmc_config_bank

// ==== rmc_cfg_sva.sv ====
// Port checker for the radio modem configuration bank.
// Assumes it is bound to rmc_config_bank and sees only its ports.
`timescale 1ns/1ns
module rmc_cfg_sva (
  // Clock and reset
  input wire core_clk,
  input wire rst_b,
  // Register port
  input wire [6:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire reg_hit,
  // Decoded outputs, with the tx_active and rx_data_valid inputs
  input wire tx_active,
  input wire [2:0] power_index,
  input wire ramp_busy,
  input wire [5:0] load_cap_tenths_pf,
  input wire carrier_only_tx,
  input wire timing_loop_kind,
  input wire [3:0] timing_int_gain,
  input wire [4:0] postfilter_size,
  input wire fc_run,
  input wire rx_data_valid,
  input wire rx_store_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire mapped = reg_addr >= 7'h15 && reg_addr <= 7'h27 && reg_addr != 7'h19;
  // ****************************************
  // Properties
  // ****************************************
  a_unmapped_read_zero: assert property (reg_rd && !mapped |=> !reg_hit && reg_rdata == 8'h00)
    else $error("unmapped read returned data");
  a_mapped_read_hit: assert property (reg_rd && mapped |=> reg_hit)
    else $error("mapped read without hit");
  a_write_read_back: assert property (reg_wr && reg_addr == 7'h1A ##1 reg_rd && !reg_wr && reg_addr == 7'h1A |=> reg_rdata == $past(reg_wdata, 2))
    else $error("read back differs from write");
  a_cap_decode: assert property (reg_wr && reg_addr == 7'h18 ##1 !reg_wr |=> load_cap_tenths_pf == 6'd12 * $past(reg_wdata[7:6], 2))
    else $error("load capacitor decode wrong");
  a_carrier_follow: assert property (reg_wr && reg_addr == 7'h1B ##1 !reg_wr |=> carrier_only_tx == $past(reg_wdata[7], 2))
    else $error("carrier mode not following write");
  a_int_gain_dll: assert property (timing_loop_kind |-> timing_int_gain == 4'h0)
    else $error("integral gain used in delay-locked mode");
  a_postfilter_size: assert property ($past(rst_b) |-> postfilter_size == 5'd8 || postfilter_size == 5'd16)
    else $error("post-filter size out of range");
  a_store_needs_valid: assert property (rx_store_en |-> $past(rx_data_valid))
    else $error("store without received data");
  a_ramp_step_up: assert property (ramp_busy ##1 ramp_busy && tx_active ##1 tx_active |-> (power_index - $past(power_index)) <= 3'h1)
    else $error("ramp index jumped");
  a_idle_no_ramp: assert property (!tx_active ##1 !tx_active |-> !ramp_busy)
    else $error("ramp busy without transmit");
  c_ramp_done: cover property (ramp_busy ##1 !ramp_busy);
  c_fc_frozen: cover property ($fell(fc_run));
  c_unmapped: cover property (reg_rd && !mapped);
endmodule // rmc_cfg_sva

bind rmc_config_bank rmc_cfg_sva u_sva (
  .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
  .tx_active(tx_active), .power_index(power_index), .ramp_busy(ramp_busy),
  .load_cap_tenths_pf(load_cap_tenths_pf), .carrier_only_tx(carrier_only_tx),
  .timing_loop_kind(timing_loop_kind), .timing_int_gain(timing_int_gain),
  .postfilter_size(postfilter_size), .fc_run(fc_run), .rx_data_valid(rx_data_valid),
  .rx_store_en(rx_store_en));

// ==== rmc_cfg_tb.sv ====
// Self-checking bench for the radio modem configuration bank.
// Assumes rmc_config_bank and its checker are compiled before it.
`timescale 1ns/1ns
module tb;
  reg core_clk = 1'b0;
  reg rst_b = 1'b0;
  reg [6:0] reg_addr = 7'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [7:0] reg_wdata = 8'h00;
  reg [34:0] upper_slots = {7'h11, 7'h22, 7'h33, 7'h44, 7'h5A};
  reg tx_active = 1'b0;
  reg [15:0] bit_period_cycles = 16'h0010;
  reg sync_seen = 1'b0;
  reg rx_frame_start = 1'b0;
  reg [7:0] strength_now = 8'h00;
  reg rx_data_valid = 1'b0;
  wire [7:0] reg_rdata, rate_mant, fc_fast_len;
  wire reg_hit, ramp_busy, carrier_only_tx, gauss_bt_half, timing_loop_kind, fc_run;
  wire fc_loop_point, strength_above, gain_loop_on, rx_store_en, antenna_swap_on;
  wire [6:0] power_level;
  wire [5:0] load_cap_tenths_pf;
  wire [4:0] fc_leak, postfilter_size;
  wire [3:0] rate_exp, dev_exp, filt_mant, filt_exp, fc_fast_gain, fc_slow_gain;
  wire [3:0] strength_filt_gain, timing_int_gain, gain_high_th, gain_low_th, gain_measure_len;
  wire [2:0] power_index, dev_mant, timing_prop_gain, antenna_measure_len;
  wire [1:0] mod_kind, cs_mode, onoff_peak_decay;
  integer n_mismatch = 0;
  integer n_compared = 0;
  // Offset, reset value and writable mask of every register
  reg [23:0] tbl [0:17] = '{24'h15407F, 24'h164E7F, 24'h17007F, 24'h1807FF, 24'h1A83FF,
    24'h1B1AFF, 24'h1C45FF, 24'h1D23FF, 24'h1E48FF, 24'h1F18FF, 24'h2025FF, 24'h21E3FF,
    24'h2224FF, 24'h2358FF, 24'h2422FF, 24'h2565FF, 24'h268AFF, 24'h27051F};

  rmc_config_bank dut (.*);

  always #2 core_clk = ~core_clk;
  // ****************************************
  // Helpers
  // ****************************************
  task step;
    @(posedge core_clk);
    #1;
  endtask
  task wr(input [6:0] a, input [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step;
    reg_wr = 1'b0;
  endtask
  task wrs(input [6:0] a, input [7:0] d);
    wr(a, d);
    step;
    step;
  endtask
  task rd(input [6:0] a, output [7:0] d, output h);
    reg_addr = a;
    reg_rd = 1'b1;
    step;
    reg_rd = 1'b0;
    d = reg_rdata;
    h = reg_hit;
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task pulse(input s);
    sync_seen = s;
    rx_frame_start = !s;
    step;
    sync_seen = 1'b0;
    rx_frame_start = 1'b0;
    step;
    step;
  endtask
  task restore;
    integer i;
    for (i = 0; i < 18; i = i + 1) wrs(tbl[i][22:16], tbl[i][15:8]);
  endtask
  task end_of_test;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset_out;
    chk(mod_kind, 8'h01);
    chk(rate_exp, 8'h0A);
    chk(fc_run, 8'h01);
    chk(fc_leak, 8'h08);
    chk(strength_filt_gain, 8'h0E);
    chk(onoff_peak_decay, 8'h03);
    chk(postfilter_size, 8'd16);
    chk(gain_loop_on, 8'h01);
    chk(antenna_measure_len, 8'h05);
    chk(power_index, 8'h07);
  endtask
  task t_regs;
    integer i;
    reg [7:0] d;
    reg h;
    for (i = 0; i < 18; i = i + 1) begin
      rd(tbl[i][22:16], d, h);
      chk(d, tbl[i][15:8]);
      chk(h, 8'h01);
      wr(tbl[i][22:16], 8'hFF);
      rd(tbl[i][22:16], d, h);
      chk(d, tbl[i][7:0]);
      wr(tbl[i][22:16], 8'h00);
      rd(tbl[i][22:16], d, h);
      chk(d, 8'h00);
      wr(tbl[i][22:16], tbl[i][15:8]);
    end
    for (i = 0; i < 2; i = i + 1) begin
      wr(i ? 7'h28 : 7'h19, 8'hFF);
      rd(i ? 7'h28 : 7'h19, d, h);
      chk(d, 8'h00);
      chk(h, 8'h00);
    end
  endtask
  task t_cap;
    integer c;
    for (c = 0; c < 8; c = c + 1) begin
      wrs(7'h18, {c[1:0], 3'b000, c[2:0]});
      chk(load_cap_tenths_pf, 12 * c[1:0]);
      chk(power_index, c);
      chk(power_level, c == 0 ? 8'h00 : c == 1 ? 8'h4E : c == 2 ? 8'h40 :
          upper_slots[(c - 3) * 7 +: 7]);
    end
  endtask
  task t_mod;
    integer k;
    reg [7:0] v;
    wrs(7'h1A, 8'h5C);
    chk(rate_mant, 8'h5C);
    for (k = 0; k < 4; k = k + 1) begin
      v = {k[0], k[1], k[1:0], k[1:0], ~k[1:0]};
      wrs(7'h1B, v);
      chk(carrier_only_tx, v[7]);
      chk(gauss_bt_half, v[6]);
      chk(mod_kind, v[5:4]);
      chk(rate_exp, v[3:0]);
    end
  endtask
  task t_fields;
    integer k;
    for (k = 0; k < 2; k = k + 1) begin
      wrs(7'h1C, k ? 8'hAE : 8'hA6);
      chk(dev_exp, 8'h0A);
      chk(dev_mant, 8'h06);
      chk(timing_loop_kind, k);
      wrs(7'h23, k ? 8'hBB : 8'hAB);
      chk(timing_prop_gain, 8'h05);
      chk(postfilter_size, k ? 8'd16 : 8'd8);
      chk(timing_int_gain, k ? 8'h00 : 8'h0B);
    end
    wrs(7'h1D, 8'h9C);
    chk({filt_mant, filt_exp}, 8'h9C);
    wrs(7'h1F, 8'h33);
    chk(fc_fast_len, 8'h33);
    wrs(7'h20, 8'h7E);
    chk({fc_fast_gain, fc_slow_gain}, 8'h7E);
    wrs(7'h21, 8'hEC);
    chk(onoff_peak_decay, 8'h00);
    chk(cs_mode, 8'h03);
    wrs(7'h25, 8'h9A);
    chk({gain_high_th, gain_low_th}, 8'h9A);
    wrs(7'h24, 8'h0C);
    chk(gain_measure_len, 8'h0C);
    wrs(7'h26, 8'h0A);
    chk(gain_loop_on, 8'h00);
    wrs(7'h27, 8'h0B);
    chk({antenna_swap_on, antenna_measure_len}, 8'h0B);
    restore;
  endtask
  task t_fc;
    wrs(7'h1E, 8'hC8);
    pulse(1'b1);
    chk(fc_run, 8'h00);
    pulse(1'b0);
    chk(fc_run, 8'h01);
    wrs(7'h1E, 8'h68);
    chk(fc_loop_point, 8'h01);
    pulse(1'b1);
    chk(fc_run, 8'h01);
    wrs(7'h1E, 8'h08);
    chk(fc_run, 8'h00);
    wrs(7'h1E, 8'h48);
  endtask
  task t_strength;
    wrs(7'h22, 8'h30);
    strength_now = 8'h30;
    wrs(7'h27, 8'h15);
    chk(strength_above, 8'h01);
    rx_data_valid = 1'b1;
    strength_now = 8'h2F;
    wrs(7'h27, 8'h15);
    chk(strength_above, 8'h00);
    chk(rx_store_en, 8'h00);
    wrs(7'h27, 8'h05);
    chk(rx_store_en, 8'h01);
    rx_data_valid = 1'b0;
    wrs(7'h22, 8'h24);
  endtask
  task t_ramp;
    integer r, i;
    integer cnt [0:7];
    reg [7:0] cfg;
    for (r = 0; r < 3; r = r + 1) begin
      cfg = r == 0 ? 8'h0B : r == 1 ? 8'h2B : 8'h3B;
      wrs(7'h18, cfg);
      for (i = 0; i < 8; i = i + 1) cnt[i] = 0;
      tx_active = 1'b1;
      for (i = 0; i < 60; i = i + 1) begin
        step;
        cnt[power_index] = cnt[power_index] + 1;
      end
      chk(cnt[1], r == 0 ? 0 : 2 * cfg[4:3]);
      chk(cnt[2], r == 0 ? 0 : 2 * cfg[4:3]);
      chk({ramp_busy, power_index}, 8'h03);
      tx_active = 1'b0;
      step;
      step;
    end
    wrs(7'h18, 8'h07);
  endtask
  // ****************************************
  // Main
  // ****************************************
  initial begin
    repeat (8) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    step;
    t_reset_out;
    t_regs;
    t_cap;
    t_mod;
    t_fields;
    t_fc;
    t_strength;
    t_ramp;
    end_of_test;
  end
endmodule // tb
